// ---- scale_monitor_pkg.sv ----
// shared constants and types for the encoder and scale configuration monitor
package scale_monitor_pkg;

    // ----------------------------------------------------------------
    // register map (word offsets on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_ENC_USAGE = 4'h0;
    localparam logic [3:0] ADDR_SCALE_CFG = 4'h1;
    localparam logic [3:0] ADDR_COMM_EXT = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_ERRORS = 4'h4;
    localparam logic [3:0] ADDR_SCALE_POS = 4'h5;
    localparam logic [3:0] ADDR_SCALE_ID = 4'h6;
    localparam logic [3:0] ADDR_MULTITURN = 4'h7;
    localparam logic [3:0] ADDR_TURN_LIMIT = 4'h8;

    // ----------------------------------------------------------------
    // setting ranges and codes
    // ----------------------------------------------------------------
    localparam logic [2:0] ENC_ABSOLUTE = 3'h0;
    localparam logic [2:0] ENC_INCREMENTAL = 3'h1;
    localparam logic [2:0] ENC_ABS_NO_OVF = 3'h2;
    localparam logic [2:0] ENC_SINGLE_TURN = 3'h3;
    localparam logic [2:0] ENC_CONTINUOUS = 3'h4;
    localparam logic [2:0] ENC_USAGE_MAX = 3'h4;
    localparam logic [2:0] ENC_USAGE_RESET = 3'h1;

    localparam logic [2:0] SCALE_AB_PHASE = 3'h0;
    localparam logic [2:0] SCALE_SERIAL_INC = 3'h1;
    localparam logic [2:0] SCALE_SERIAL_ABS = 3'h2;
    localparam logic [2:0] SCALE_SERIAL_ROT = 3'h6;
    localparam logic [2:0] SCALE_TYPE_RESET = 3'h0;

    localparam logic [1:0] DIR_MAX = 2'h1;
    localparam int COMM_MONITOR_BIT = 4;

    // field positions in the scale configuration word
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_DIR_LSB = 4;
    localparam int CFG_INDEX_BIT = 8;

    // field positions in the status word
    localparam int ST_MON_BIT = 0;
    localparam int ST_ABS_BIT = 1;
    localparam int ST_MT_BIT = 2;
    localparam int ST_CFG_BIT = 3;

    localparam logic [15:0] TURN_LIMIT_RESET = 16'hFFFF;

    // arbitrary neutral scale identity value
    localparam logic [31:0] SCALE_ID_DEFAULT = 32'h0000_0001;

    // ----------------------------------------------------------------
    // carried types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic absSystemDown;
        logic absCounterOver;
        logic absOverspeed;
        logic absMultiturnCounter;
        logic multiturnOverflow;
    } enc_faults_t;

    typedef struct packed {
        logic disconnect;
        logic commFault;
        logic statusFault;
        logic indexLost;
        logic typeMismatch;
    } scale_faults_t;

    typedef struct packed {
        logic absSystemDownError;
        logic absCounterOverError;
        logic absOverspeedError;
        logic absMultiturnCounterError;
        logic commandErrorProtection;
        logic scaleConnectionError;
        logic scaleWarningA;
        logic scaleWarningB;
    } errors_t;

endpackage

// ---- absolute_encoder_scale_monitor.sv ----
// encoder usage, scale configuration and scale position monitor
`timescale 1ns/100ps
`default_nettype none
module absolute_encoder_scale_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    input wire logic fullClosed,
    input wire logic [1:0] controlMode,
    input wire logic fastCommCycle,
    input wire logic cycleStrobe,
    input wire logic homingDone,
    input wire logic [31:0] encoderPosition,
    input wire logic [15:0] encoderMultiturn,
    input wire logic scaleStep,
    input wire logic scaleUp,
    input wire logic [31:0] scaleAbsolute,
    input wire logic scaleAbsValid,
    input wire logic [2:0] connectedScaleType,
    input wire scale_monitor_pkg::enc_faults_t encFaults,
    input wire scale_monitor_pkg::scale_faults_t scaleFaults,
    output scale_monitor_pkg::errors_t errors,
    output logic [31:0] reportedPosition,
    output logic reportValid
);
    import scale_monitor_pkg::*;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [2:0] encUsage_q;
    logic [2:0] scaleType_q;
    logic [1:0] scaleDir_q;
    logic indexCheckOff_q;
    logic [15:0] commExt_q;
    logic [15:0] turnLimit_q;

    function automatic logic scaleTypeLegal(input logic [2:0] code);
        return (code <= SCALE_SERIAL_ABS) || (code == SCALE_SERIAL_ROT);
    endfunction

    function automatic logic isWrite(input logic [3:0] a);
        return regWrite && (regAddr == a);
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            encUsage_q <= ENC_USAGE_RESET;
        end else if (isWrite(ADDR_ENC_USAGE) && regWrData[2:0] <= ENC_USAGE_MAX
                     && regWrData[31:3] == '0) begin
            encUsage_q <= regWrData[2:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scaleType_q <= SCALE_TYPE_RESET;
            scaleDir_q <= 2'h0;
            indexCheckOff_q <= 1'b0;
        end else if (isWrite(ADDR_SCALE_CFG)) begin
            // reserved codes are refused so the previous valid mode stays
            if (scaleTypeLegal(regWrData[CFG_TYPE_LSB +: 3])) begin
                scaleType_q <= regWrData[CFG_TYPE_LSB +: 3];
            end
            if (regWrData[CFG_DIR_LSB +: 2] <= DIR_MAX) begin
                scaleDir_q <= regWrData[CFG_DIR_LSB +: 2];
            end
            indexCheckOff_q <= regWrData[CFG_INDEX_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            commExt_q <= 16'h0000;
        end else if (isWrite(ADDR_COMM_EXT)) begin
            commExt_q <= regWrData[15:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            turnLimit_q <= TURN_LIMIT_RESET;
        end else if (isWrite(ADDR_TURN_LIMIT) && encUsage_q == ENC_CONTINUOUS) begin
            turnLimit_q <= regWrData[15:0];
        end
    end

    // ----------------------------------------------------------------
    // effective mode decode
    // ----------------------------------------------------------------
    logic [2:0] effUsage;
    logic absMode;
    logic multiturnUsed;
    logic overflowIgnored;
    logic monitorOn;
    logic scaleReport;
    logic modeSupported;

    assign effUsage = fullClosed ? ENC_INCREMENTAL : encUsage_q;
    assign absMode = (effUsage != ENC_INCREMENTAL);
    assign multiturnUsed = absMode && (effUsage != ENC_SINGLE_TURN);
    assign overflowIgnored = (effUsage == ENC_ABS_NO_OVF) || (effUsage == ENC_CONTINUOUS);
    // the three semi-closed modes are codes 0..2; code 3 is not a control mode
    assign modeSupported = (controlMode != 2'h3);
    assign monitorOn = !fullClosed && commExt_q[COMM_MONITOR_BIT] && modeSupported;
    assign scaleReport = fullClosed || monitorOn;

    // ----------------------------------------------------------------
    // error detection
    // ----------------------------------------------------------------
    logic [2:0] connSync1_q;
    logic [2:0] connSync2_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            connSync1_q <= 3'h0;
            connSync2_q <= 3'h0;
        end else begin
            connSync1_q <= connectedScaleType;
            connSync2_q <= connSync1_q;
        end
    end

    // errors are latched until the next power-on reset, as a protection trips
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            errors <= '0;
        end else begin
            if (absMode && encFaults.absSystemDown) errors.absSystemDownError <= 1'b1;
            if (absMode && encFaults.absCounterOver) errors.absCounterOverError <= 1'b1;
            if (absMode && encFaults.absOverspeed) errors.absOverspeedError <= 1'b1;
            if (multiturnUsed && (encFaults.absMultiturnCounter
                || (encFaults.multiturnOverflow && !overflowIgnored))) begin
                errors.absMultiturnCounterError <= 1'b1;
            end
            if (monitorOn && fastCommCycle) errors.commandErrorProtection <= 1'b1;
            if (scaleReport && (connSync2_q != scaleType_q || scaleFaults.typeMismatch)) begin
                errors.scaleConnectionError <= 1'b1;
            end
            if (scaleReport && (scaleFaults.disconnect || (scaleType_q == SCALE_AB_PHASE
                && !indexCheckOff_q && scaleFaults.indexLost))) begin
                errors.scaleWarningA <= 1'b1;
            end
            if (scaleReport && (scaleFaults.commFault || scaleFaults.statusFault)) begin
                errors.scaleWarningB <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // scale position counter
    // ----------------------------------------------------------------
    logic [31:0] scalePos_q;
    logic stepUp;

    assign stepUp = scaleUp ^ (scaleDir_q == 2'h1);

    // homingDone is deliberately not a clear term here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scalePos_q <= 32'h0000_0000;
        end else if (scaleType_q != SCALE_AB_PHASE && scaleType_q != SCALE_SERIAL_INC
                     && scaleAbsValid) begin
            scalePos_q <= (scaleDir_q == 2'h1) ? (32'h0000_0000 - scaleAbsolute) : scaleAbsolute;
        end else if (scaleStep) begin
            scalePos_q <= stepUp ? scalePos_q + 32'h0000_0001 : scalePos_q - 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // cyclic response
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reportedPosition <= 32'h0000_0000;
            reportValid <= 1'b0;
        end else begin
            reportValid <= cycleStrobe;
            if (cycleStrobe) begin
                reportedPosition <= fullClosed ? scalePos_q : encoderPosition;
            end
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 32'h0000_0000;
        end else if (regRead) begin
            unique case (regAddr)
                ADDR_ENC_USAGE: regRdData <= {29'h0, encUsage_q};
                ADDR_SCALE_CFG: regRdData <= {23'h0, indexCheckOff_q, 2'h0, scaleDir_q,
                                              1'b0, scaleType_q};
                ADDR_COMM_EXT: regRdData <= {16'h0, commExt_q};
                ADDR_STATUS: regRdData <= {28'h0, scaleReport, multiturnUsed, absMode,
                                           monitorOn};
                ADDR_ERRORS: regRdData <= {24'h0, errors};
                ADDR_SCALE_POS: regRdData <= scaleReport ? scalePos_q : 32'h0000_0000;
                ADDR_SCALE_ID: regRdData <= scaleReport ? SCALE_ID_DEFAULT : 32'h0000_0000;
                ADDR_MULTITURN: regRdData <= {16'h0, encoderMultiturn};
                ADDR_TURN_LIMIT: regRdData <= {16'h0, turnLimit_q};
                default: regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence usageWrite_s;
        regWrite && (regAddr == ADDR_ENC_USAGE) && regWrData > 32'h0000_0004;
    endsequence

    property usageHeld_p;
        @(posedge clk) disable iff (!reset_n) usageWrite_s |=> $stable(encUsage_q);
    endproperty

    usage_range_a: assert property (usageHeld_p) else $error("usage took illegal value");

    inc_masks_abs_a: assert property (@(posedge clk) disable iff (!reset_n)
        (effUsage == ENC_INCREMENTAL && !errors.absSystemDownError) |=>
        !errors.absSystemDownError) else $error("abs error set in incremental mode");

    full_closed_inc_a: assert property (@(posedge clk) disable iff (!reset_n)
        fullClosed |-> !absMode) else $error("full-closed not incremental");

    single_turn_mt_a: assert property (@(posedge clk) disable iff (!reset_n)
        (encUsage_q == ENC_SINGLE_TURN) |-> !multiturnUsed) else $error("multiturn used");

    overflow_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
        (overflowIgnored && !encFaults.absMultiturnCounter && !errors.absMultiturnCounterError)
        |=> !errors.absMultiturnCounterError) else $error("overflow flagged");

    cmd_error_a: assert property (@(posedge clk) disable iff (!reset_n)
        (monitorOn && fastCommCycle) |=> errors.commandErrorProtection)
        else $error("command error not raised");

    scale_type_a: assert property (@(posedge clk) disable iff (!reset_n)
        scaleTypeLegal(scaleType_q)) else $error("reserved scale type held");

    report_abs_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cycleStrobe && !fullClosed) |=> reportValid && reportedPosition == $past(encoderPosition))
        else $error("response lacks absolute data");

    homing_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (homingDone && !scaleStep && !scaleAbsValid) |=> $stable(scalePos_q))
        else $error("scale position cleared at homing");

    inc_mask_cnt_a: assert property (@(posedge clk) disable iff (!reset_n)
        (effUsage == ENC_INCREMENTAL && !errors.absCounterOverError) |=>
        !errors.absCounterOverError) else $error("counter over in incremental mode");

    inc_mask_spd_a: assert property (@(posedge clk) disable iff (!reset_n)
        (effUsage == ENC_INCREMENTAL && !errors.absOverspeedError) |=>
        !errors.absOverspeedError) else $error("overspeed in incremental mode");

    inc_mask_mt_a: assert property (@(posedge clk) disable iff (!reset_n)
        (effUsage == ENC_INCREMENTAL && !errors.absMultiturnCounterError) |=>
        !errors.absMultiturnCounterError) else $error("multiturn in incremental mode");

    abs_err_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        (absMode && encFaults.absSystemDown) |=> errors.absSystemDownError)
        else $error("system down not flagged");

    usage_max_a: assert property (@(posedge clk) disable iff (!reset_n)
        encUsage_q <= ENC_USAGE_MAX)
        else $error("usage above range");

    continuous_ovf_a: assert property (@(posedge clk) disable iff (!reset_n)
        (encUsage_q == ENC_CONTINUOUS && !fullClosed) |-> overflowIgnored)
        else $error("continuous mode flags overflow");

    limit_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == ADDR_TURN_LIMIT && encUsage_q != ENC_CONTINUOUS) |=>
        $stable(turnLimit_q)) else $error("turn limit taken outside usage four");

    dir_range_a: assert property (@(posedge clk) disable iff (!reset_n)
        scaleDir_q <= DIR_MAX)
        else $error("reserved direction held");

    monitor_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!fullClosed && !commExt_q[COMM_MONITOR_BIT]) |-> !scaleReport)
        else $error("scale reported with monitor off");

    full_report_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cycleStrobe && fullClosed) |=> reportedPosition == $past(scalePos_q))
        else $error("response lacks scale position");

    mode_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (controlMode == 2'h3 && !fullClosed) |-> !scaleReport)
        else $error("monitor on outside semi-closed modes");

    conn_err_a: assert property (@(posedge clk) disable iff (!reset_n)
        (scaleReport && connSync2_q != scaleType_q) |=> errors.scaleConnectionError)
        else $error("connection error not raised");

    index_skip_a: assert property (@(posedge clk) disable iff (!reset_n)
        (indexCheckOff_q && !scaleFaults.disconnect && !errors.scaleWarningA) |=>
        !errors.scaleWarningA) else $error("index check ran while disabled");

    warn_b_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        (scaleReport && scaleFaults.commFault) |=> errors.scaleWarningB)
        else $error("scale warning not raised");

    sequence idReadHidden_s;
        regRead && (regAddr == ADDR_SCALE_ID) && !scaleReport;
    endsequence

    id_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        idReadHidden_s |=> (regRdData == 32'h0000_0000)) else $error("scale id readable");

    step_invert_a: assert property (@(posedge clk) disable iff (!reset_n)
        (scaleStep && scaleUp && scaleDir_q == 2'h1 && scaleType_q == SCALE_SERIAL_INC) |=>
        scalePos_q == $past(scalePos_q) - 32'h0000_0001) else $error("inverted step counted up");

endmodule // absolute_encoder_scale_monitor
`default_nettype wire

// ---- host_model.sv ----
// host controller model that polls the cyclic position report
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic reportValid,
    input wire logic [31:0] reportedPosition,
    output logic cycleStrobe,
    output logic [31:0] lastPos,
    output logic [7:0] nReports
);
    logic [1:0] phase_q;
    // one cyclic request every fourth cycle while running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 2'h0;
            cycleStrobe <= 1'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
            cycleStrobe <= run && (phase_q == 2'h3);
        end
    end
    // position taken only in the cycle the answer stands; multi-turn data never used
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lastPos <= 32'h0000_0000;
            nReports <= 8'h00;
        end else if (reportValid) begin
            lastPos <= reportedPosition;
            nReports <= nReports + 8'h01;
        end
    end
endmodule // host_model
`default_nettype wire

// ---- test_absolute_encoder_scale_monitor.sv ----
// self-checking bench for the encoder and scale configuration monitor
`timescale 1ns/100ps
`default_nettype none
module test_absolute_encoder_scale_monitor;
    import scale_monitor_pkg::*;
    logic clk, reset_n, regWrite, regRead, fullClosed, fastCommCycle, cycleStrobe, homingDone;
    logic scaleStep, scaleUp, scaleAbsValid, run, reportValid;
    logic [3:0] regAddr;
    logic [31:0] regWrData, regRdData, encoderPosition, scaleAbsolute, reportedPosition, lastPos;
    logic [1:0] controlMode;
    logic [15:0] encoderMultiturn;
    logic [2:0] connectedScaleType;
    logic [7:0] nReports;
    enc_faults_t encFaults;
    scale_faults_t scaleFaults;
    errors_t errors;
    int bad_count, n_tests, cycles;

    absolute_encoder_scale_monitor u_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .fullClosed(fullClosed), .controlMode(controlMode), .fastCommCycle(fastCommCycle),
        .cycleStrobe(cycleStrobe), .homingDone(homingDone), .encoderPosition(encoderPosition),
        .encoderMultiturn(encoderMultiturn), .scaleStep(scaleStep), .scaleUp(scaleUp),
        .scaleAbsolute(scaleAbsolute), .scaleAbsValid(scaleAbsValid),
        .connectedScaleType(connectedScaleType), .encFaults(encFaults),
        .scaleFaults(scaleFaults), .errors(errors), .reportedPosition(reportedPosition),
        .reportValid(reportValid));
    host_model u_host (.clk(clk), .reset_n(reset_n), .run(run), .reportValid(reportValid),
        .reportedPosition(reportedPosition), .cycleStrobe(cycleStrobe), .lastPos(lastPos),
        .nReports(nReports));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'h1;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask
    task automatic rc(input string name, input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk);
        regRead <= 1'h0;
        @(posedge clk);
        chk(name, regRdData, exp);
    endtask
    task automatic cfg(input logic [31:0] d, input logic [2:0] connected);
        connectedScaleType <= connected;
        wr(ADDR_SCALE_CFG, d);
    endtask
    task automatic steps(input int n, input logic up);
        repeat (n) begin
            @(posedge clk);
            scaleStep <= 1'h1;
            scaleUp <= up;
            @(posedge clk);
            scaleStep <= 1'h0;
        end
    endtask
    task automatic rst();
        @(posedge clk);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
    endtask
    task automatic hostReport();
        logic [7:0] n0;
        n0 = nReports;
        run <= 1'h1;
        for (int i = 0; i < 20 && nReports == n0; i++) @(posedge clk);
        run <= 1'h0;
        chk("report", {24'h0, nReports}, {24'h0, n0 + 8'h01});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_usage();
        rc("usageRst", ADDR_ENC_USAGE, 32'h0000_0001);
        rc("limitRst", ADDR_TURN_LIMIT, 32'h0000_FFFF);
        rc("unmapped", 4'h9, 32'h0000_0000);
        for (int i = 0; i <= 4; i++) begin
            wr(ADDR_ENC_USAGE, 32'(i));
            rc("usage", ADDR_ENC_USAGE, 32'(i));
        end
        wr(ADDR_ENC_USAGE, 32'h0000_0005);
        rc("usage5", ADDR_ENC_USAGE, 32'h0000_0004);
        wr(ADDR_TURN_LIMIT, 32'h0000_1234);
        rc("limit4", ADDR_TURN_LIMIT, 32'h0000_1234);
        wr(ADDR_ENC_USAGE, 32'h0000_0000);
        wr(ADDR_TURN_LIMIT, 32'h0000_5678);
        rc("limit0", ADDR_TURN_LIMIT, 32'h0000_1234);
    endtask
    task automatic t_masks();
        rst();
        encFaults <= 5'b11110;
        repeat (3) @(posedge clk);
        chk("incMask", {28'h0, errors[7:4]}, 32'h0000_0000);
        encFaults <= 5'b00001;
        wr(ADDR_ENC_USAGE, {29'h0, ENC_ABS_NO_OVF});
        repeat (2) @(posedge clk);
        chk("ovfIgnored2", {31'h0, errors.absMultiturnCounterError}, 32'h0000_0000);
        wr(ADDR_ENC_USAGE, {29'h0, ENC_CONTINUOUS});
        repeat (2) @(posedge clk);
        chk("ovfIgnored4", {31'h0, errors.absMultiturnCounterError}, 32'h0000_0000);
        wr(ADDR_ENC_USAGE, {29'h0, ENC_SINGLE_TURN});
        rc("singleMt", ADDR_STATUS, 32'h0000_0002);
        wr(ADDR_ENC_USAGE, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("ovfFlagged", {31'h0, errors.absMultiturnCounterError}, 32'h0000_0001);
        encFaults <= 5'b11110;
        wr(ADDR_ENC_USAGE, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("absErr", {28'h0, errors[7:4]}, 32'h0000_000F);
        encFaults <= 5'b00000;
    endtask
    task automatic t_full();
        rst();
        wr(ADDR_ENC_USAGE, 32'h0000_0000);
        fullClosed <= 1'h1;
        encFaults <= 5'b11110;
        repeat (3) @(posedge clk);
        chk("fcMask", {28'h0, errors[7:4]}, 32'h0000_0000);
        encFaults <= 5'b00000;
        cfg(32'h0000_0001, 3'h1);
        steps(3, 1'h1);
        hostReport();
        chk("fcReport", lastPos, 32'h0000_0003);
        @(posedge clk);
        homingDone <= 1'h1;
        @(posedge clk);
        homingDone <= 1'h0;
        rc("homing", ADDR_SCALE_POS, 32'h0000_0003);
        encoderMultiturn <= 16'h0007;
        rc("mtRaw", ADDR_MULTITURN, 32'h0000_0007);
        encoderMultiturn <= 16'h0000;
        rst();
        rc("powerOn", ADDR_SCALE_POS, 32'h0000_0000);
        rc("mtClear", ADDR_MULTITURN, 32'h0000_0000);
        fullClosed <= 1'h0;
    endtask
    task automatic t_semi();
        wr(ADDR_ENC_USAGE, 32'h0000_0000);
        encoderPosition <= 32'h0001_2345;
        hostReport();
        chk("absReport", lastPos, 32'h0001_2345);
        scaleFaults <= 5'b10000;
        repeat (3) @(posedge clk);
        chk("monOffWarn", {31'h0, errors.scaleWarningA}, 32'h0000_0000);
        rc("monOffId", ADDR_SCALE_ID, 32'h0000_0000);
        scaleFaults <= 5'b00000;
        wr(ADDR_COMM_EXT, 32'h0000_0010);
        cfg(32'h0000_0001, 3'h1);
        steps(3, 1'h1);
        cfg(32'h0000_0011, 3'h1);
        steps(4, 1'h1);
        for (int m = 0; m < 3; m++) begin
            controlMode <= 2'(m);
            rc("invertPos", ADDR_SCALE_POS, 32'hFFFF_FFFF);
        end
        rc("monId", ADDR_SCALE_ID, SCALE_ID_DEFAULT);
        controlMode <= 2'h3;
        rc("mode3", ADDR_SCALE_POS, 32'h0000_0000);
        controlMode <= 2'h0;
        cfg(32'h0000_0100, 3'h0);
        scaleFaults <= 5'b00010;
        repeat (3) @(posedge clk);
        chk("idxOff", {31'h0, errors.scaleWarningA}, 32'h0000_0000);
        cfg(32'h0000_0000, 3'h0);
        repeat (2) @(posedge clk);
        chk("idxOn", {31'h0, errors.scaleWarningA}, 32'h0000_0001);
        scaleFaults <= 5'b01000;
        repeat (3) @(posedge clk);
        chk("commWarn", {31'h0, errors.scaleWarningB}, 32'h0000_0001);
        scaleFaults <= 5'b00000;
    endtask
    task automatic t_errs();
        rst();
        fastCommCycle <= 1'h1;
        repeat (3) @(posedge clk);
        chk("cmdOff", {31'h0, errors.commandErrorProtection}, 32'h0000_0000);
        wr(ADDR_COMM_EXT, 32'h0000_0010);
        repeat (2) @(posedge clk);
        chk("cmdOn", {31'h0, errors.commandErrorProtection}, 32'h0000_0001);
        fastCommCycle <= 1'h0;
        connectedScaleType <= 3'h2;
        repeat (5) @(posedge clk);
        chk("connErr", {31'h0, errors.scaleConnectionError}, 32'h0000_0001);
        cfg(32'h0000_0003, 3'h3);
        rc("type3", ADDR_SCALE_CFG, 32'h0000_0000);
        cfg(32'h0000_0006, 3'h6);
        rc("type6", ADDR_SCALE_CFG, 32'h0000_0006);
        scaleAbsolute <= 32'h0000_0100;
        scaleAbsValid <= 1'h1;
        @(posedge clk);
        scaleAbsValid <= 1'h0;
        rc("absScale", ADDR_SCALE_POS, 32'h0000_0100);
        cfg(32'h0000_0026, 3'h6);
        rc("dir2", ADDR_SCALE_CFG, 32'h0000_0006);
        cfg(32'h0000_0016, 3'h6);
        scaleAbsValid <= 1'h1;
        @(posedge clk);
        scaleAbsValid <= 1'h0;
        rc("absInvert", ADDR_SCALE_POS, 32'hFFFF_FF00);
    endtask

    // ----------------------------------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        {reset_n, regWrite, regRead, fullClosed, fastCommCycle, homingDone} = '0;
        {scaleStep, scaleUp, scaleAbsValid, run, controlMode, connectedScaleType} = '0;
        {regAddr, regWrData, encoderPosition, scaleAbsolute, encoderMultiturn} = '0;
        encFaults = '0;
        scaleFaults = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        t_usage();
        t_masks();
        t_full();
        t_semi();
        t_errs();
        results();
    end
endmodule // test_absolute_encoder_scale_monitor
`default_nettype wire
